// ---- bench/board_reset_model.sv ----
// board reset source that sits on the far side of the clock front end
// assumes one core clock; hold is counted in core cycles
`timescale 1ns/1ps
`default_nettype none
module board_reset_model
(
	input wire logic aclk,
	input wire logic start,
	input wire logic [15:0] hold_cycles,
	output logic reset_in_n
);
	logic [15:0] left = 16'h0000;
	logic low_n = 1'b0;
	assign reset_in_n = low_n;
	always @(posedge aclk)
	begin
		if (start)
		begin
			// never shorter than four input periods at the slowest ratio
			left <= (hold_cycles < 16'h0010) ? 16'h0010 : hold_cycles;
			low_n <= 1'b0;
		end
		else if (left > 16'h0001)
			left <= left - 16'h0001;
		else
			low_n <= 1'b1;
	end
endmodule
`default_nettype wire

// ---- bench/tb_core_clock_and_reset_sync.sv ----
// self-checking bench for the clock and reset front end
// assumes the design package and the reset source model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_core_clock_and_reset_sync;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [3:0] core_ratio_select_pins = 4'h0, general_flag_pins = 4'h0;
	logic [2:0] external_interrupt_request_n = 3'h7;
	wire logic reset_in_n;
	logic core_reset_n, arb_resync, input_clock_tick, ext_port_clock;
	logic [5:0] link_clock_tick, link_clock;
	logic [1:0] serial_tx_tick, serial_rx_tick, serial_tx_clock, serial_rx_clock;
	logic [2:0] irq_recognised;
	logic [3:0] flag_effective;
	logic rst_start = 1'b0;
	logic [15:0] rst_hold = 16'h0028;
	int error_cnt = 0;
	int tests_run = 0;
	// levels from bit 11 up, ticks below
	wire logic [21:0] probe = {serial_rx_clock, serial_tx_clock, link_clock, ext_port_clock,
		serial_rx_tick, serial_tx_tick, link_clock_tick, input_clock_tick};

	always #5 aclk = ~aclk;

	core_clock_front #(.LOCK_CYCLES(20)) dut
	(
		.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_ratio_select_pins, .reset_in_n,
		.external_interrupt_request_n, .general_flag_pins, .core_reset_n, .arb_resync,
		.input_clock_tick, .ext_port_clock, .link_clock_tick, .link_clock,
		.serial_tx_tick, .serial_rx_tick, .serial_tx_clock, .serial_rx_clock,
		.irq_recognised, .flag_effective
	);

	board_reset_model partner
	(
		.aclk,
		.start(rst_start),
		.hold_cycles(rst_hold),
		.reset_in_n
	);

	// ************************************************
	// shared tasks
	// ************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		$display("mismatches %0d of %0d checks", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do @(posedge aclk); while (!(s_axi_awready === 1'b1 && s_axi_wready === 1'b1) && ++n < 50);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		while (s_axi_bvalid !== 1'b1 && ++n < 50) @(posedge aclk);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		chk(n < 50, 1'b1);
	endtask

	task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do @(posedge aclk); while (s_axi_arready !== 1'b1 && ++n < 50);
		s_axi_arvalid <= 1'b0;
		while (s_axi_rvalid !== 1'b1 && ++n < 50) @(posedge aclk);
		d = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		chk(n < 50, 1'b1);
	endtask

	// high samples of one probe bit over 24 cycles; 24 is a multiple of every period used
	task automatic count_hi(input int idx, input int exp_n);
		int c;
		c = 0;
		repeat (24)
		begin
			@(negedge aclk);
			if (probe[idx] === 1'b1)
				c++;
		end
		chk(c, exp_n);
	endtask

	task automatic wait_run;
		int n;
		for (n = 0; n < 200 && core_reset_n !== 1'b1; n++) @(negedge aclk);
		chk(arb_resync, 1'b1);
		@(negedge aclk);
		chk(arb_resync, 1'b0);
	endtask

	// ************************************************
	// sequence
	// ************************************************
	initial
	begin
		logic [1:0] resp;
		logic [31:0] rd;
		int r, c, n;
		int lf[6] = '{0, 1, 2, 3, 1, 3};
		int lh[6] = '{24, 12, 8, 12, 12, 12};
		for (c = 0; c < 4; c++)
		begin
			r = (c == 1) ? 3 : (c == 2) ? 4 : 2;
			@(posedge aclk);
			aresetn <= 1'b0;
			core_ratio_select_pins <= c[3:0];
			rst_hold <= 16'h0028;
			rst_start <= 1'b1;
			@(posedge aclk);
			rst_start <= 1'b0;
			@(posedge aclk);
			aresetn <= 1'b1;
			wait_run();
			@(posedge aclk);
			core_ratio_select_pins <= ~c[3:0];
			axi_rd(clock_front_pkg::ADDR_STATUS, rd, resp);
			chk(rd, 32'h0000_0030 | r);
			count_hi(0, 24 / r);
			count_hi(11, (24 / r) * (r / 2));
		end
		axi_wr(clock_front_pkg::ADDR_LINK_DIV, 32'h0000_0de4, resp);
		chk(resp, clock_front_pkg::RESP_OKAY);
		for (c = 0; c < 6; c++) count_hi(1 + c, 24 / (lf[c] + 1));
		for (c = 0; c < 6; c++) count_hi(12 + c, lh[c]);
		axi_rd(clock_front_pkg::ADDR_LINK_DIV, rd, resp);
		chk(rd, 32'h0000_0de4);
		axi_wr(clock_front_pkg::ADDR_SER_DIV0, 32'h0008_0006, resp);
		axi_wr(clock_front_pkg::ADDR_SER_DIV1, 32'h0000_000c, resp);
		count_hi(7, 4);
		count_hi(8, 2);
		count_hi(9, 3);
		count_hi(10, 24);
		count_hi(18, 12);
		count_hi(19, 12);
		count_hi(20, 12);
		count_hi(21, 24);
		axi_wr(12'h010, 32'h0000_00ff, resp);
		chk(resp, clock_front_pkg::RESP_SLVERR);
		axi_rd(12'h010, rd, resp);
		chk(rd, 32'h0000_0000);
		chk(resp, clock_front_pkg::RESP_SLVERR);
		axi_wr(clock_front_pkg::ADDR_STATUS, 32'h0000_0000, resp);
		chk(resp, clock_front_pkg::RESP_OKAY);
		axi_rd(clock_front_pkg::ADDR_STATUS, rd, resp);
		chk(rd, 32'h0000_0032);
		@(posedge aclk);
		general_flag_pins <= 4'ha;
		@(negedge aclk);
		@(negedge aclk);
		chk(flag_effective, 4'h0);
		@(negedge aclk);
		chk(flag_effective, 4'ha);
		@(posedge aclk);
		external_interrupt_request_n <= 3'h6;
		for (n = 0; n < 4 && irq_recognised !== 3'h1; n++) @(negedge aclk);
		chk(irq_recognised, 3'h1);
		@(posedge aclk);
		external_interrupt_request_n <= 3'h7;
		for (n = 0; n < 4 && irq_recognised !== 3'h0; n++) @(negedge aclk);
		chk(irq_recognised, 3'h0);
		// short request is stretched by the reset source
		@(posedge aclk);
		core_ratio_select_pins <= 4'h1;
		rst_hold <= 16'h0001;
		rst_start <= 1'b1;
		@(posedge aclk);
		rst_start <= 1'b0;
		repeat (3) @(negedge aclk);
		chk(core_reset_n, 1'b0);
		wait_run();
		axi_rd(clock_front_pkg::ADDR_STATUS, rd, resp);
		chk(rd, 32'h0000_0033);
		complete_run();
	end

	initial
	begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		complete_run();
	end
endmodule
`default_nettype wire

// ---- logic/clock_div_if.sv ----
// ratio, run and tick between the front end and one divider
// assumes both ends sit on the same core clock
`timescale 1ns/1ps
`default_nettype none
interface clock_div_if #(parameter int W = 16);
	logic [W-1:0] ratio;
	logic run;
	logic tick;
	logic level;
	modport owner(output ratio, output run, input tick, input level);
	modport divider(input ratio, input run, output tick, output level);
endinterface
`default_nettype wire

// ---- logic/clock_divider.sv ----
// one programmable period divider on the core clock
// assumes ratio 0 means 1; tick marks the last core cycle of each period
`timescale 1ns/1ps
`default_nettype none
module clock_divider #(parameter int W = 16)
(
	input wire logic aclk,
	input wire logic aresetn,
	clock_div_if.divider port
);
	typedef struct packed
	{
		logic [W-1:0] cnt;
		logic level;
	} div_state_t;

	div_state_t cur;
	div_state_t next_cur;
	logic [W-1:0] eff;

	assign eff = (port.ratio == '0) ? W'(1) : port.ratio;
	// >= so a ratio lowered mid-period wraps at once
	assign port.tick = port.run && (cur.cnt >= eff - W'(1));
	assign port.level = cur.level;

	always_comb
	begin
		next_cur = cur;
		if (!port.run)
			next_cur.cnt = '0;
		else if (port.tick)
			next_cur.cnt = '0;
		else
			next_cur.cnt = cur.cnt + W'(1);
		// ratio 1 has no half period; level stays high
		next_cur.level = (eff == W'(1)) || (next_cur.cnt < (eff >> 1));
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cur <= '0;
		else
			cur <= next_cur;
	end

	AST_DIV_SPACING: assert property (@(posedge aclk) disable iff (!aresetn)
		(port.tick && port.run && port.ratio == W'(3)) ##1 (port.run && port.ratio == W'(3))
		[*3] |-> port.tick && $past(port.tick, 1) == 1'b0)
		else $error("divider tick spacing does not follow ratio");
	AST_DIV_IDLE: assert property (@(posedge aclk) disable iff (!aresetn)
		!port.run |=> cur.cnt == '0)
		else $error("divider counts while stopped");
endmodule
`default_nettype wire

// ---- logic/clock_front_pkg.sv ----
// constants shared by the clock and reset front end and its divider
// assumes a single 100 MHz core-side clock and an AXI4-Lite register master
//
// Notes on behaviour
// - core clock is input clock times 2/3/4
// - link clock period is core times 1..4
// - serial clock period is core times programmed ratio
// - external port clock toggles at input rate
// - multiplied clock times memory, core and ports
// - aligned release leaves reset on same edge
// - bus arbitration resynchronises itself after reset
// - sampled interrupt recognised in the next cycle
// - flag input affects cycle N+2
package clock_front_pkg;
	// ************************************************
	// timing
	// ************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int LOCK_WAIT_MS = 100;
	// longest wait, so rounded down
	localparam int LOCK_WAIT_CYCLES = LOCK_WAIT_MS * 1000000 / CLK_PERIOD_NS;

	// ************************************************
	// widths
	// ************************************************
	localparam int CFG_WIDTH = 4;
	localparam int RATIO_WIDTH = 3;
	localparam int LINK_PORTS = 6;
	localparam int LINK_FIELD_WIDTH = 2;
	localparam int SERIAL_PORTS = 2;
	localparam int SER_DIV_WIDTH = 16;
	localparam int IRQ_WIDTH = 3;
	localparam int FLAG_WIDTH = 4;
	localparam int ADDR_WIDTH = 12;

	// ************************************************
	// register map
	// ************************************************
	localparam logic [11:0] ADDR_LINK_DIV = 12'h000;
	localparam logic [11:0] ADDR_SER_DIV0 = 12'h004;
	localparam logic [11:0] ADDR_SER_DIV1 = 12'h008;
	localparam logic [11:0] ADDR_STATUS = 12'h00c;
	localparam logic [11:0] LINK_DIV_RESET = 12'h000;
	localparam logic [15:0] SER_DIV_RESET = 16'h0000;
	localparam int STAT_RATIO_LSB = 0;
	localparam int STAT_LOCKED_BIT = 4;
	localparam int STAT_RUN_BIT = 5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ************************************************
	// core ratio codes
	// ************************************************
	localparam logic [2:0] RATIO_2 = 3'h2;
	localparam logic [2:0] RATIO_3 = 3'h3;
	localparam logic [2:0] RATIO_4 = 3'h4;

	typedef enum logic [2:0]
	{
		ST_LOCK_WAIT = 3'h1,
		ST_HELD = 3'h2,
		ST_RUN = 3'h4
	} rst_state_t;

	function automatic logic [2:0] decode_core_ratio(input logic [3:0] pins);
		case (pins[1:0])
			2'h1: decode_core_ratio = RATIO_3;
			2'h2: decode_core_ratio = RATIO_4;
			default: decode_core_ratio = RATIO_2;
		endcase
	endfunction
endpackage

// ---- logic/core_clock_front.sv ----
// clock ratio, reset sequencing and input sampling front end
// assumes aclk is the multiplied core clock; the input clock rate is
// recovered as a tick every core-ratio cycles
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module core_clock_front #(parameter int LOCK_CYCLES = clock_front_pkg::LOCK_WAIT_CYCLES)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] core_ratio_select_pins,
	input wire logic reset_in_n,
	input wire logic [2:0] external_interrupt_request_n,
	input wire logic [3:0] general_flag_pins,
	output logic core_reset_n,
	output logic arb_resync,
	output logic input_clock_tick,
	output logic ext_port_clock,
	output logic [5:0] link_clock_tick,
	output logic [5:0] link_clock,
	output logic [1:0] serial_tx_tick,
	output logic [1:0] serial_rx_tick,
	output logic [1:0] serial_tx_clock,
	output logic [1:0] serial_rx_clock,
	output logic [2:0] irq_recognised,
	output logic [3:0] flag_effective
);
	localparam int LCW = $clog2(LOCK_CYCLES + 1);
	localparam int NSER = 2 * clock_front_pkg::SERIAL_PORTS;

	typedef struct packed
	{
		clock_front_pkg::rst_state_t state;
		logic [LCW-1:0] lock_cnt;
		logic [2:0] core_ratio;
		logic arb_resync;
		logic [2:0] irq;
		logic [3:0] flag_p1;
		logic [3:0] flag_eff;
		logic [11:0] link_div;
		logic [NSER-1:0][15:0] ser_div;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
	} front_state_t;

	front_state_t cur;
	front_state_t next_cur;
	logic running;
	logic ck_tick;
	logic wr_fire;
	logic rd_fire;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		merge = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				merge[8*b +: 8] = data[8*b +: 8];
		end
	endfunction

	// ************************************************
	// dividers
	// ************************************************
	clock_div_if #(.W(clock_front_pkg::RATIO_WIDTH)) in_div();
	assign in_div.ratio = cur.core_ratio;
	assign in_div.run = 1'b1;
	assign ck_tick = in_div.tick;
	clock_divider #(.W(clock_front_pkg::RATIO_WIDTH)) u_in_div
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.port(in_div.divider)
	);
	assign input_clock_tick = ck_tick;
	// bus-facing clock runs from the core clock but at input rate
	assign ext_port_clock = in_div.level;

	for (genvar i = 0; i < clock_front_pkg::LINK_PORTS; i++)
	begin : g_link
		clock_div_if #(.W(clock_front_pkg::RATIO_WIDTH)) lnk();
		assign lnk.ratio = {1'b0, cur.link_div[2*i +: 2]} + 3'h1;
		assign lnk.run = running;
		assign link_clock_tick[i] = lnk.tick;
		assign link_clock[i] = lnk.level;
		clock_divider #(.W(clock_front_pkg::RATIO_WIDTH)) u_div
		(
			.aclk(aclk),
			.aresetn(aresetn),
			.port(lnk.divider)
		);
	end

	for (genvar i = 0; i < NSER; i++)
	begin : g_ser
		clock_div_if #(.W(clock_front_pkg::SER_DIV_WIDTH)) ser();
		assign ser.ratio = cur.ser_div[i];
		assign ser.run = running;
		if (i % 2 == 0)
		begin : g_tx
			assign serial_tx_tick[i/2] = ser.tick;
			assign serial_tx_clock[i/2] = ser.level;
		end
		else
		begin : g_rx
			assign serial_rx_tick[i/2] = ser.tick;
			assign serial_rx_clock[i/2] = ser.level;
		end
		clock_divider #(.W(clock_front_pkg::SER_DIV_WIDTH)) u_div
		(
			.aclk(aclk),
			.aresetn(aresetn),
			.port(ser.divider)
		);
	end

	// ************************************************
	// register bus
	// ************************************************
	// both write channels are taken together; one answer outstanding
	assign wr_fire = s_axi_awvalid && s_axi_wvalid && !cur.bvalid;
	assign rd_fire = s_axi_arvalid && !cur.rvalid;
	assign s_axi_awready = wr_fire;
	assign s_axi_wready = wr_fire;
	assign s_axi_arready = rd_fire;
	assign s_axi_bvalid = cur.bvalid;
	assign s_axi_bresp = cur.bresp;
	assign s_axi_rvalid = cur.rvalid;
	assign s_axi_rresp = cur.rresp;
	assign s_axi_rdata = cur.rdata;

	assign running = (cur.state == clock_front_pkg::ST_RUN);
	assign core_reset_n = running;
	assign arb_resync = cur.arb_resync;
	assign irq_recognised = cur.irq;
	assign flag_effective = cur.flag_eff;

	// ************************************************
	// next state
	// ************************************************
	always_comb
	begin
		next_cur = cur;
		next_cur.arb_resync = 1'b0;
		case (cur.state)
			clock_front_pkg::ST_LOCK_WAIT:
			begin
				next_cur.core_ratio = clock_front_pkg::decode_core_ratio(core_ratio_select_pins);
				next_cur.lock_cnt = cur.lock_cnt + LCW'(1);
				if (cur.lock_cnt >= LCW'(LOCK_CYCLES - 1))
					next_cur.state = clock_front_pkg::ST_HELD;
			end
			clock_front_pkg::ST_HELD:
			begin
				next_cur.core_ratio = clock_front_pkg::decode_core_ratio(core_ratio_select_pins);
				// leave only on an input clock edge so peers stay in step
				if (reset_in_n && ck_tick)
				begin
					next_cur.state = clock_front_pkg::ST_RUN;
					next_cur.arb_resync = 1'b1;
				end
			end
			clock_front_pkg::ST_RUN:
			begin
				if (!reset_in_n)
					next_cur.state = clock_front_pkg::ST_HELD;
			end
			default:
				next_cur.state = clock_front_pkg::ST_LOCK_WAIT;
		endcase

		if (ck_tick)
			next_cur.irq = ~external_interrupt_request_n;
		next_cur.flag_p1 = general_flag_pins;
		next_cur.flag_eff = cur.flag_p1;

		if (s_axi_bready)
			next_cur.bvalid = 1'b0;
		if (wr_fire)
		begin
			next_cur.bvalid = 1'b1;
			next_cur.bresp = clock_front_pkg::RESP_OKAY;
			case (s_axi_awaddr)
				clock_front_pkg::ADDR_LINK_DIV:
					next_cur.link_div = 12'(merge(32'(cur.link_div), s_axi_wdata, s_axi_wstrb));
				clock_front_pkg::ADDR_SER_DIV0:
					next_cur.ser_div[1:0] = merge(cur.ser_div[1:0], s_axi_wdata, s_axi_wstrb);
				clock_front_pkg::ADDR_SER_DIV1:
					next_cur.ser_div[3:2] = merge(cur.ser_div[3:2], s_axi_wdata, s_axi_wstrb);
				clock_front_pkg::ADDR_STATUS:
					next_cur.bresp = clock_front_pkg::RESP_OKAY;
				default:
					next_cur.bresp = clock_front_pkg::RESP_SLVERR;
			endcase
		end

		if (s_axi_rready)
			next_cur.rvalid = 1'b0;
		if (rd_fire)
		begin
			next_cur.rvalid = 1'b1;
			next_cur.rresp = clock_front_pkg::RESP_OKAY;
			case (s_axi_araddr)
				clock_front_pkg::ADDR_LINK_DIV:
					next_cur.rdata = 32'(cur.link_div);
				clock_front_pkg::ADDR_SER_DIV0:
					next_cur.rdata = cur.ser_div[1:0];
				clock_front_pkg::ADDR_SER_DIV1:
					next_cur.rdata = cur.ser_div[3:2];
				clock_front_pkg::ADDR_STATUS:
				begin
					next_cur.rdata = 32'h0000_0000;
					next_cur.rdata[clock_front_pkg::STAT_RATIO_LSB +: 3] = cur.core_ratio;
					next_cur.rdata[clock_front_pkg::STAT_LOCKED_BIT] =
						(cur.state != clock_front_pkg::ST_LOCK_WAIT);
					next_cur.rdata[clock_front_pkg::STAT_RUN_BIT] = running;
				end
				default:
				begin
					next_cur.rdata = 32'h0000_0000;
					next_cur.rresp = clock_front_pkg::RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cur <= '0;
			cur.state <= clock_front_pkg::ST_LOCK_WAIT;
			cur.core_ratio <= clock_front_pkg::RATIO_2;
			cur.link_div <= clock_front_pkg::LINK_DIV_RESET;
			cur.ser_div <= {NSER{clock_front_pkg::SER_DIV_RESET}};
		end
		else
			cur <= next_cur;
	end

	// ************************************************
	// checks
	// ************************************************
	AST_RATIO_HELD: assert property (@(posedge aclk) disable iff (!aresetn)
		running && $past(running) |-> $stable(cur.core_ratio))
		else $error("core ratio changed while running");
	AST_RATIO_FROM_PINS: assert property (@(posedge aclk) disable iff (!aresetn)
		(cur.state == clock_front_pkg::ST_HELD && next_cur.state == clock_front_pkg::ST_HELD)
		|=> cur.core_ratio == clock_front_pkg::decode_core_ratio($past(core_ratio_select_pins)))
		else $error("core ratio not taken from pins in reset");
	AST_INPUT_TICK_RATIO2: assert property (@(posedge aclk) disable iff (!aresetn)
		(ck_tick && cur.core_ratio == clock_front_pkg::RATIO_2) ##1
		(cur.core_ratio == clock_front_pkg::RATIO_2) [*2] |-> ck_tick && $past(ck_tick) == 1'b0)
		else $error("input clock tick not every two core cycles");
	AST_RELEASE_ALIGNED: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(core_reset_n) |-> $past(ck_tick) && $past(reset_in_n))
		else $error("reset released off an input clock edge");
	AST_ARB_WITH_RELEASE: assert property (@(posedge aclk) disable iff (!aresetn)
		arb_resync == $rose(core_reset_n))
		else $error("arbitration restart not paired with release");
	AST_IRQ_NEXT: assert property (@(posedge aclk) disable iff (!aresetn)
		ck_tick |=> irq_recognised == ~$past(external_interrupt_request_n))
		else $error("sampled interrupt not recognised next cycle");
	AST_FLAG_LATENCY: assert property (@(posedge aclk) disable iff (!aresetn)
		$past(aresetn, 2) |-> flag_effective == $past(general_flag_pins, 2))
		else $error("flag latency is not two cycles");
	AST_RUN_LOCKED: assert property (@(posedge aclk) disable iff (!aresetn)
		!running |-> link_clock_tick == '0 && serial_tx_tick == '0)
		else $error("port clocks tick while core held");
endmodule
`default_nettype wire
